// >>> design/pwt_core.v
// Position wrap, wrap-setting check and 64-entry motion table with APB access
`timescale 1ns/1ns
`include "pwt_defines.vh"

module pwt_core #(
   parameter GEAR_W = 16,
   parameter MROT_W = 16
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Nonvolatile table source
   output wire nv_req,
   output wire [5:0] nv_addr,
   input wire nv_ack,
   input wire [`PWT_ENTRY_W-1:0] nv_rdata,
   // Motion interface
   input wire step_en,
   input wire step_dir,
   input wire moving,
   input wire move_start,
   input wire [5:0] move_index,
   input wire home_done,
   input wire preset_in,
   // Selected entry for the motion generator
   output reg signed [23:0] op_pos,
   output reg [19:0] op_speed,
   output reg absolute_target_mode,
   output reg [1:0] op_func,
   output reg [19:0] op_acc,
   output reg [19:0] op_dec,
   output reg acc_unit_time,
   output reg [8:0] op_push,
   output reg op_seq,
   output reg [15:0] op_dwell,
   // Position and protection
   output reg signed [23:0] cmd_pos,
   output reg [MROT_W-1:0] multi_rot,
   output reg ot_stop,
   output reg ot_stop_mode,
   output reg wrap_warn,
   output reg wrap_alarm,
   output wire table_ready
);

   localparam ST_LOAD = 2'd0;
   localparam ST_RECALC = 2'd1;
   localparam ST_RUN = 2'd2;

   // True when n is a whole multiple of d; zero divisor fails
   function is_int;
      input [63:0] n;
      input [63:0] d;
      begin
         is_int = (d != 64'h0) && ((n % d) == 64'h0);
      end
   endfunction

   reg [1:0] st_q;
   reg [5:0] ld_idx_q;
   reg [5:0] ctrl_q;
   reg [23:0] wrap_q;
   reg [GEAR_W-1:0] gear_a_q;
   reg [GEAR_W-1:0] gear_b_q;
   reg signed [23:0] preset_q;
   reg signed [23:0] lim_p_q;
   reg signed [23:0] lim_n_q;
   reg [19:0] com_acc_q;
   reg [19:0] com_dec_q;
   reg [5:0] t_idx_q;
   reg [`PWT_ENTRY_W-1:0] stage_q;
   reg pend_q;
   reg origin_q;
   reg abs_lost_q;
   reg [15:0] rev_q;
   reg [`PWT_ENTRY_W-1:0] tbl_mem [0:63];
   reg [31:0] rdata;
   reg addr_ok;

   wire wr = psel & penable & pwrite;
   wire [`PWT_ENTRY_W-1:0] run_entry = tbl_mem[move_index];
   wire [`PWT_ENTRY_W-1:0] idx_entry = tbl_mem[t_idx_q];
   wire wrap_on = ctrl_q[`PWT_C_WRAP_EN];
   wire cmd_wr = wr && (paddr == `PWT_A_CMD);
   wire do_commit = (st_q == ST_RUN) && (pend_q || (cmd_wr && pwdata[`PWT_K_COMMIT]))
                    && !moving;
   wire do_config = cmd_wr && pwdata[`PWT_K_CONFIG];
   wire [31:0] wr_u = pwdata;
   wire [23:0] pos_inc = cmd_pos + 24'h000001;
   wire [23:0] pos_dec = cmd_pos - 24'h000001;
   wire [23:0] wrap_m1 = wrap_q - 24'h000001;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata = (psel & penable & ~pwrite & addr_ok) ? rdata : 32'h0;
   assign nv_req = (st_q == ST_LOAD);
   assign nv_addr = ld_idx_q;
   assign table_ready = (st_q == ST_RUN);

   // Register read mux and address decode
   always @*
   begin
      rdata = 32'h0;
      addr_ok = 1'b1;
      case (paddr)
         `PWT_A_CTRL: rdata = {26'h0, ctrl_q};
         `PWT_A_STATUS: rdata = {25'h0, abs_lost_q, ot_stop, table_ready, pend_q,
                                 origin_q, wrap_alarm, wrap_warn};
         `PWT_A_WRAP: rdata = {8'h0, wrap_q};
         `PWT_A_GEAR_A: rdata = {{(32-GEAR_W){1'b0}}, gear_a_q};
         `PWT_A_GEAR_B: rdata = {{(32-GEAR_W){1'b0}}, gear_b_q};
         `PWT_A_CPOS: rdata = {{8{cmd_pos[23]}}, cmd_pos};
         `PWT_A_MROT: rdata = {{(32-MROT_W){1'b0}}, multi_rot};
         `PWT_A_PRESET: rdata = {{8{preset_q[23]}}, preset_q};
         `PWT_A_LIM_P: rdata = {{8{lim_p_q[23]}}, lim_p_q};
         `PWT_A_LIM_N: rdata = {{8{lim_n_q[23]}}, lim_n_q};
         `PWT_A_COM_ACC: rdata = {12'h0, com_acc_q};
         `PWT_A_COM_DEC: rdata = {12'h0, com_dec_q};
         `PWT_A_T_IDX: rdata = {26'h0, t_idx_q};
         `PWT_A_T_POS: rdata = {{8{stage_q[23]}}, stage_q[`PWT_E_POS]};
         `PWT_A_T_SPD: rdata = {12'h0, stage_q[`PWT_E_SPD]};
         `PWT_A_T_ACC: rdata = {12'h0, stage_q[`PWT_E_ACC]};
         `PWT_A_T_DEC: rdata = {12'h0, stage_q[`PWT_E_DEC]};
         `PWT_A_T_MISC: rdata = {19'h0, stage_q[`PWT_E_PUSH], stage_q[`PWT_E_SEQ],
                                 stage_q[`PWT_E_FUNC], stage_q[`PWT_E_MODE]};
         `PWT_A_T_DWELL: rdata = {16'h0, stage_q[`PWT_E_DWELL]};
         `PWT_A_CMD: rdata = 32'h0;
         default: addr_ok = 1'b0;
      endcase
   end

   // Configuration registers written from APB
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q <= `PWT_CTRL_RST;
         wrap_q <= `PWT_WRAP_RST;
         gear_a_q <= `PWT_GEAR_RST;
         gear_b_q <= `PWT_GEAR_RST;
         preset_q <= 24'h0;
         lim_p_q <= `PWT_LIM_P_RST;
         lim_n_q <= `PWT_LIM_N_RST;
         com_acc_q <= `PWT_ACC_RST;
         com_dec_q <= `PWT_ACC_RST;
         t_idx_q <= 6'h0;
      end
      else if (wr)
      begin
         case (paddr)
            `PWT_A_CTRL: ctrl_q <= wr_u[5:0];
            `PWT_A_WRAP:
               if (wr_u != 32'h0 && wr_u <= `PWT_WRAP_MAX)
                  wrap_q <= wr_u[23:0];
            `PWT_A_GEAR_A: gear_a_q <= wr_u[GEAR_W-1:0];
            `PWT_A_GEAR_B: gear_b_q <= wr_u[GEAR_W-1:0];
            `PWT_A_PRESET: preset_q <= wr_u[23:0];
            `PWT_A_LIM_P: lim_p_q <= wr_u[23:0];
            `PWT_A_LIM_N: lim_n_q <= wr_u[23:0];
            `PWT_A_COM_ACC:
               if (wr_u != 32'h0 && wr_u <= `PWT_ACC_MAX)
                  com_acc_q <= wr_u[19:0];
            `PWT_A_COM_DEC:
               if (wr_u != 32'h0 && wr_u <= `PWT_ACC_MAX)
                  com_dec_q <= wr_u[19:0];
            `PWT_A_T_IDX: t_idx_q <= wr_u[5:0];
            default: ;
         endcase
      end
   end

   // Staging entry; out-of-range field writes are ignored
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_q <= {`PWT_ENTRY_W{1'b0}};
         stage_q[`PWT_E_SPD] <= `PWT_SPD_RST;
         stage_q[`PWT_E_ACC] <= `PWT_ACC_RST;
         stage_q[`PWT_E_DEC] <= `PWT_ACC_RST;
         stage_q[`PWT_E_PUSH] <= `PWT_PUSH_RST;
      end
      else if (cmd_wr && pwdata[`PWT_K_FETCH] && table_ready)
         stage_q <= idx_entry;
      else if (wr && !pend_q)
      begin
         case (paddr)
            `PWT_A_T_POS: stage_q[`PWT_E_POS] <= wr_u[23:0];
            `PWT_A_T_SPD:
               if (wr_u <= `PWT_SPD_MAX)
                  stage_q[`PWT_E_SPD] <= wr_u[19:0];
            `PWT_A_T_ACC:
               if (wr_u != 32'h0 && wr_u <= `PWT_ACC_MAX)
                  stage_q[`PWT_E_ACC] <= wr_u[19:0];
            `PWT_A_T_DEC:
               if (wr_u != 32'h0 && wr_u <= `PWT_ACC_MAX)
                  stage_q[`PWT_E_DEC] <= wr_u[19:0];
            `PWT_A_T_MISC:
            begin
               stage_q[`PWT_E_MODE] <= wr_u[`PWT_M_MODE];
               stage_q[`PWT_E_FUNC] <= wr_u[`PWT_M_FUNC_LO+1:`PWT_M_FUNC_LO];
               stage_q[`PWT_E_SEQ] <= wr_u[`PWT_M_SEQ];
               if (wr_u[`PWT_M_PUSH_LO+8:`PWT_M_PUSH_LO] <= `PWT_PUSH_MAX)
                  stage_q[`PWT_E_PUSH] <= wr_u[`PWT_M_PUSH_LO+8:`PWT_M_PUSH_LO];
            end
            `PWT_A_T_DWELL:
               if (wr_u <= `PWT_DWELL_MAX)
                  stage_q[`PWT_E_DWELL] <= wr_u[15:0];
            default: ;
         endcase
      end
   end

   // Working table: volatile, filled from NV, then by host commits only
   always @(posedge clk)
   begin
      if (st_q == ST_LOAD && nv_ack)
         tbl_mem[ld_idx_q] <= nv_rdata;
      else if (do_commit)
         tbl_mem[t_idx_q] <= stage_q;
   end

   // Power-up sequence: copy all entries, then one recalculation cycle
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= ST_LOAD;
         ld_idx_q <= 6'h0;
      end
      else
      begin
         case (st_q)
            ST_LOAD:
               if (nv_ack)
               begin
                  ld_idx_q <= ld_idx_q + 6'h1;
                  if (ld_idx_q == `PWT_LAST_IDX)
                     st_q <= ST_RECALC;
               end
            ST_RECALC: st_q <= ST_RUN;
            ST_RUN: st_q <= ST_RUN;
            default: st_q <= ST_LOAD;
         endcase
      end
   end

   // Deferred commit while the motor is moving
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pend_q <= 1'b0;
      else if (do_commit)
         pend_q <= 1'b0;
      else if (cmd_wr && pwdata[`PWT_K_COMMIT] && table_ready)
         pend_q <= 1'b1;
   end

   // Wrap-setting warning and alarm
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wrap_warn <= 1'b0;
         wrap_alarm <= 1'b0;
      end
      else
      begin
         wrap_warn <= wrap_on &&
            !(is_int({48'h0, gear_b_q} * `PWT_CHK_B, {48'h0, gear_a_q} * `PWT_CHK_A) &&
              is_int({40'h0, wrap_q} * gear_a_q * `PWT_CHK_A,
                     {48'h0, gear_b_q} * `PWT_CHK_B));
         if (wrap_warn && (st_q == ST_RECALC || do_config))
            wrap_alarm <= 1'b1;
         else if (cmd_wr && pwdata[`PWT_K_ALM_CLR])
            wrap_alarm <= 1'b0;
      end
   end

   // Hint that the absolute position may be stale after wrap changes
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         abs_lost_q <= 1'b0;
      else if (ctrl_q[`PWT_C_ABS_BKP] && wr &&
               ((paddr == `PWT_A_WRAP) ||
                (paddr == `PWT_A_CTRL && wr_u[`PWT_C_WRAP_EN] != wrap_on)))
         abs_lost_q <= 1'b1;
      else if (home_done || preset_in || (cmd_wr && pwdata[`PWT_K_ABS_CLR]))
         abs_lost_q <= 1'b0;
   end

   // Command position, multi-rotation count and origin
   // With wrap on, negative or out-of-range positions fold back into range
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd_pos <= 24'h0;
         multi_rot <= {MROT_W{1'b0}};
         rev_q <= 16'h0;
         origin_q <= 1'b0;
      end
      else if (home_done || preset_in)
      begin
         cmd_pos <= home_done ? 24'h0 : preset_q;
         multi_rot <= {MROT_W{1'b0}};
         rev_q <= 16'h0;
         origin_q <= 1'b1;
      end
      else if (step_en)
      begin
         if (wrap_on && step_dir && $unsigned(cmd_pos) >= wrap_m1)
         begin
            cmd_pos <= 24'h0;
            multi_rot <= {MROT_W{1'b0}};
            rev_q <= 16'h0;
         end
         else if (wrap_on && !step_dir && (cmd_pos == 24'h0 || $unsigned(cmd_pos) >= wrap_q))
         begin
            cmd_pos <= wrap_m1;
            multi_rot <= {MROT_W{1'b0}};
            rev_q <= 16'h0;
         end
         else
         begin
            cmd_pos <= step_dir ? pos_inc : pos_dec;
            if (step_dir && rev_q == `PWT_STEPS_REV - 16'h1)
            begin
               rev_q <= 16'h0;
               multi_rot <= multi_rot + {{(MROT_W-1){1'b0}}, 1'b1};
            end
            else if (!step_dir && rev_q == 16'h0)
            begin
               rev_q <= `PWT_STEPS_REV - 16'h1;
               multi_rot <= multi_rot - {{(MROT_W-1){1'b0}}, 1'b1};
            end
            else
               rev_q <= step_dir ? rev_q + 16'h1 : rev_q - 16'h1;
         end
      end
   end

   // Software overtravel, suppressed while wrapping
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ot_stop <= 1'b0;
         ot_stop_mode <= 1'b0;
      end
      else
      begin
         ot_stop <= ctrl_q[`PWT_C_SWOT_EN] && !wrap_on && origin_q &&
                    (cmd_pos > lim_p_q || cmd_pos < lim_n_q);
         ot_stop_mode <= ctrl_q[`PWT_C_OT_MODE];
      end
   end

   // Latch the selected entry at move start
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         op_pos <= 24'h0;
         op_speed <= `PWT_SPD_RST;
         absolute_target_mode <= 1'b0;
         op_func <= 2'h0;
         op_acc <= `PWT_ACC_RST;
         op_dec <= `PWT_ACC_RST;
         acc_unit_time <= 1'b0;
         op_push <= `PWT_PUSH_RST;
         op_seq <= 1'b0;
         op_dwell <= 16'h0;
      end
      else if (move_start && table_ready)
      begin
         op_pos <= run_entry[`PWT_E_POS];
         op_speed <= run_entry[`PWT_E_SPD];
         absolute_target_mode <= run_entry[`PWT_E_MODE];
         op_func <= run_entry[`PWT_E_FUNC];
         op_acc <= ctrl_q[`PWT_C_RAMP_SEP] ? run_entry[`PWT_E_ACC] : com_acc_q;
         op_dec <= ctrl_q[`PWT_C_RAMP_SEP] ? run_entry[`PWT_E_DEC] : com_dec_q;
         acc_unit_time <= ctrl_q[`PWT_C_ACC_UNIT];
         op_push <= run_entry[`PWT_E_PUSH];
         op_seq <= run_entry[`PWT_E_SEQ];
         op_dwell <= (run_entry[`PWT_E_FUNC] == `PWT_FUNC_DWELL) ?
                     run_entry[`PWT_E_DWELL] : 16'h0;
      end
   end

endmodule // pwt_core

// >>> design/pwt_defines.vh
// Register map, field positions, reset values and encodings for pwt_core
`ifndef PWT_DEFINES_VH
`define PWT_DEFINES_VH

// APB byte offsets
`define PWT_A_CTRL 8'h00
`define PWT_A_STATUS 8'h04
`define PWT_A_WRAP 8'h08
`define PWT_A_GEAR_A 8'h0C
`define PWT_A_GEAR_B 8'h10
`define PWT_A_CPOS 8'h14
`define PWT_A_MROT 8'h18
`define PWT_A_PRESET 8'h1C
`define PWT_A_LIM_P 8'h20
`define PWT_A_LIM_N 8'h24
`define PWT_A_COM_ACC 8'h28
`define PWT_A_COM_DEC 8'h2C
`define PWT_A_T_IDX 8'h30
`define PWT_A_T_POS 8'h34
`define PWT_A_T_SPD 8'h38
`define PWT_A_T_ACC 8'h3C
`define PWT_A_T_DEC 8'h40
`define PWT_A_T_MISC 8'h44
`define PWT_A_T_DWELL 8'h48
`define PWT_A_CMD 8'h4C

// Control bits
`define PWT_C_WRAP_EN 0
`define PWT_C_RAMP_SEP 1
`define PWT_C_SWOT_EN 2
`define PWT_C_ACC_UNIT 3
`define PWT_C_ABS_BKP 4
`define PWT_C_OT_MODE 5
`define PWT_CTRL_RST 6'h02
// Command bits
`define PWT_K_COMMIT 0
`define PWT_K_FETCH 1
`define PWT_K_CONFIG 2
`define PWT_K_ALM_CLR 3
`define PWT_K_ABS_CLR 4
// Status bits
`define PWT_S_WARN 0
`define PWT_S_ALARM 1
`define PWT_S_ORIGIN 2
`define PWT_S_PEND 3
`define PWT_S_READY 4
`define PWT_S_OT 5
`define PWT_S_ABS_LOST 6
// Misc staging field: mode bit0, function 2:1, sequential 3, push 12:4
`define PWT_M_MODE 0
`define PWT_M_FUNC_LO 1
`define PWT_M_SEQ 3
`define PWT_M_PUSH_LO 4

// Table entry packing
`define PWT_E_POS 23:0
`define PWT_E_SPD 43:24
`define PWT_E_ACC 63:44
`define PWT_E_DEC 83:64
`define PWT_E_PUSH 92:84
`define PWT_E_DWELL 108:93
`define PWT_E_MODE 109
`define PWT_E_FUNC 111:110
`define PWT_E_SEQ 112
`define PWT_ENTRY_W 113

// Reset and limit values
`define PWT_WRAP_RST 24'h0003E8
`define PWT_WRAP_MAX 32'h007FFFFF
`define PWT_SPD_RST 20'h003E8
`define PWT_SPD_MAX 32'h000F4240
`define PWT_ACC_RST 20'h003E8
`define PWT_ACC_MAX 32'h000F4240
`define PWT_PUSH_RST 9'h0C8
`define PWT_PUSH_MAX 9'h1F4
`define PWT_DWELL_MAX 32'h0000C350
`define PWT_GEAR_RST 16'h0001
`define PWT_CHK_B 32'h000003E8
`define PWT_CHK_A 32'h00000032
`define PWT_STEPS_REV 16'h03E8
`define PWT_LIM_P_RST 24'h7FFFFF
`define PWT_LIM_N_RST 24'h800000
`define PWT_LAST_IDX 6'h3F
`define PWT_FUNC_DWELL 2'h2

`endif

// >>> bench/pwt_props.sv
// Checker for the position wrap and motion table core
`timescale 1ns/1ns
module pwt_props #(
   parameter MROT_W = 16
) (
   // Clock, reset and bus
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Table load and motion
   input wire nv_req,
   input wire [5:0] nv_addr,
   input wire nv_ack,
   input wire step_en,
   input wire step_dir,
   input wire home_done,
   input wire preset_in,
   input wire [1:0] op_func,
   input wire [15:0] op_dwell,
   // Position and protection
   input wire signed [23:0] cmd_pos,
   input wire [MROT_W-1:0] multi_rot,
   input wire ot_stop,
   input wire wrap_warn,
   input wire wrap_alarm,
   input wire table_ready
);
   logic wr;
   logic up;
   logic wrap_q;
   logic [23:0] rng_q;
   // Bus write strobe and wrapped step
   assign wr = psel && penable && pwrite && pready;
   assign up = step_en && !home_done && !preset_in && wrap_q;
   // Shadow of wrap enable and range
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         wrap_q <= 1'b0;
         rng_q <= 24'h0003E8;
      end
      else if (wr && paddr == 8'h00)
         wrap_q <= pwdata[0];
      else if (wr && paddr == 8'h08 && pwdata != 32'h0 && pwdata <= 32'h007FFFFF)
         rng_q <= pwdata[23:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h4C |-> pslverr)
      else $error("unmapped access not refused");
   a_nv_advance: assert property (nv_req && nv_ack && nv_addr != 6'h3F
      |=> nv_addr == $past(nv_addr) + 6'h01)
      else $error("load index did not advance");
   a_load_first: assert property (nv_req |-> !table_ready)
      else $error("ready during load");
   a_ready_after: assert property (nv_req && nv_ack && nv_addr == 6'h3F
      |=> !table_ready ##1 table_ready)
      else $error("ready not one cycle after recalc");
   a_wrap_up: assert property (up && step_dir
      && int'(cmd_pos) + 1 >= int'(rng_q) |=> cmd_pos == 0 && multi_rot == 0)
      else $error("no wrap at range");
   a_wrap_range: assert property (up
      |=> cmd_pos >= 0 && int'(cmd_pos) < int'(rng_q))
      else $error("position out of wrap range");
   a_wrap_down: assert property (up && !step_dir && cmd_pos == 0
      |=> int'(cmd_pos) == int'(rng_q) - 1)
      else $error("down step from zero wrong");
   a_swot_off: assert property (wrap_q && $past(wrap_q) |-> !ot_stop)
      else $error("overtravel stop with wrap on");
   a_warn_idle: assert property (!wrap_q && !$past(wrap_q) |-> !wrap_warn)
      else $error("warning with wrap off");
   a_alarm_config: assert property (wr && paddr == 8'h4C && pwdata[2] && wrap_warn
      |=> wrap_alarm)
      else $error("no alarm on configuration");
   a_dwell_func: assert property (op_func != 2'h2 |-> op_dwell == 16'h0)
      else $error("dwell outside function 2");
   c_wrap: cover property (up && step_dir ##1 cmd_pos == 0);
   c_alarm: cover property (wrap_alarm);
   c_refuse: cover property (pslverr);
endmodule // pwt_props

// >>> bench/pwt_nv_model.sv
// Retained table storage answering the core's power-on load
`timescale 1ns/1ns
module pwt_nv_model (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Load handshake
   input wire nv_req,
   input wire [5:0] nv_addr,
   output logic nv_ack,
   output wire [112:0] nv_rdata
);
   logic [2:0] cnt_q;
   logic done_q;
   // Fixed content, never written, survives power loss
   function automatic [112:0] entry(input [5:0] i);
      entry = {i[2], i[1:0], i[0], {10'h000, i}, {3'h0, i}, 20'h00BB8, 20'h007D0,
         20'h003E8 + {14'h0000, i}, {18'h00000, i} - 24'h000020};
   endfunction
   // Released data shows the inverse, not the last entry
   assign nv_rdata = nv_ack ? entry(nv_addr) : ~entry(nv_addr);
   // Prompt on even entries, three cycles late on odd ones
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         cnt_q <= 3'h0;
         nv_ack <= 1'b0;
         done_q <= 1'b0;
      end
      else if (nv_ack || !nv_req || done_q)
      begin
         nv_ack <= 1'b0;
         cnt_q <= 3'h0;
      end
      else if (cnt_q == (nv_addr[0] ? 3'h3 : 3'h0))
      begin
         nv_ack <= 1'b1;
         done_q <= nv_addr == 6'h3F;
      end
      else
         cnt_q <= cnt_q + 3'h1;
endmodule // pwt_nv_model

// >>> bench/pwt_core_test.sv
// Testbench for the position wrap and motion table core
`timescale 1ns/1ns
`include "pwt_defines.vh"
module pwt_core_test;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic nv_req, nv_ack, step_en, step_dir, moving, move_start, home_done, preset_in;
   logic [5:0] nv_addr, move_index;
   logic [112:0] nv_rdata;
   logic signed [23:0] op_pos, cmd_pos;
   logic [19:0] op_speed, op_acc, op_dec;
   logic absolute_target_mode, acc_unit_time, op_seq, ot_stop, ot_stop_mode;
   logic [1:0] op_func;
   logic [8:0] op_push;
   logic [15:0] op_dwell, multi_rot;
   logic wrap_warn, wrap_alarm, table_ready;
   integer err_total, num_checks, i;
   pwt_core i_pwt_core (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .nv_req, .nv_addr, .nv_ack, .nv_rdata, .step_en, .step_dir,
      .moving, .move_start, .move_index, .home_done, .preset_in, .op_pos, .op_speed,
      .absolute_target_mode, .op_func, .op_acc, .op_dec, .acc_unit_time, .op_push,
      .op_seq, .op_dwell, .cmd_pos, .multi_rot, .ot_stop, .ot_stop_mode, .wrap_warn,
      .wrap_alarm, .table_ready);
   pwt_nv_model i_pwt_nv_model (.clk, .nrst, .nv_req, .nv_addr, .nv_ack, .nv_rdata);
   // Compare and count
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Verdict and stop
   task end_of_test;
      begin
         $display("TB: %0d checks, %0d errors", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task hang;
      begin
         err_total = err_total + 1;
         end_of_test;
      end
   endtask
   // One APB transfer, setup then access until ready
   task apb(input [7:0] a, input w, input [31:0] d);
      integer n;
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         @(posedge clk);
         while (pready !== 1'b1)
         begin
            n = n + 1;
            if (n > 16)
               hang;
            @(posedge clk);
         end
         rd_v = prdata;
         perr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         apb(a, 1'b0, 32'h0);
         chk(rd_v, e);
      end
   endtask
   task wait_ready;
      integer n;
      begin
         n = 0;
         while (table_ready !== 1'b1)
         begin
            n = n + 1;
            if (n > 600)
               hang;
            @(posedge clk);
         end
      end
   endtask
   // Start a move on one entry
   task mv(input [5:0] k);
      begin
         move_index <= k;
         move_start <= 1'b1;
         @(posedge clk);
         move_start <= 1'b0;
         @(posedge clk);
      end
   endtask
   task steps(input dir, input integer k);
      begin
         step_dir <= dir;
         step_en <= 1'b1;
         repeat (k) @(posedge clk);
         step_en <= 1'b0;
         @(posedge clk);
      end
   endtask
   task chk_op(input [112:0] e);
      begin
         chk(op_pos[23:0], e[23:0]);
         chk(op_speed, e[43:24]);
         chk(op_acc, e[63:44]);
         chk(op_push, e[92:84]);
         chk(absolute_target_mode, e[109]);
         chk(op_func, e[111:110]);
         chk(op_seq, e[112]);
         chk(op_dwell, e[111:110] == 2'h2 ? e[108:93] : 16'h0000);
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Main sequence
   initial
   begin
      err_total = 0;
      num_checks = 0;
      {nrst, psel, penable, pwrite, step_en, step_dir, moving, move_start} = 8'h00;
      {home_done, preset_in, paddr, pwdata, move_index} = 48'h0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      chk(op_speed, 32'h000003E8);
      chk(op_push, 32'h000000C8);
      rd(`PWT_A_CTRL, 32'h00000002);
      rd(`PWT_A_WRAP, 32'h000003E8);
      wait_ready;
      for (i = 0; i < 64; i = i + 21)
      begin
         mv(i[5:0]);
         chk_op(i_pwt_nv_model.entry(i[5:0]));
      end
      wr(`PWT_A_CTRL, 32'h00000000);
      mv(6'h15);
      chk(op_dec, 32'h000003E8);
      wr(`PWT_A_CTRL, 32'h0000000A);
      mv(6'h15);
      chk(op_dec, 32'h00000BB8);
      chk(acc_unit_time, 32'h1);
      $display("TB: test load and table done");
      wr(`PWT_A_T_IDX, 32'h00000003);
      wr(`PWT_A_CMD, 32'h00000002);
      wr(`PWT_A_T_POS, 32'hFF800000);
      wr(`PWT_A_T_SPD, 32'h000F4241);
      moving <= 1'b1;
      wr(`PWT_A_CMD, 32'h00000001);
      mv(6'h03);
      chk(op_pos[23:0], 32'h00FFFFE3);
      moving <= 1'b0;
      @(posedge clk);
      mv(6'h03);
      chk(op_pos[23:0], 32'h00800000);
      chk(op_speed, 32'h000003EB);
      wr(`PWT_A_CMD, 32'h00000002);
      rd(`PWT_A_T_POS, 32'hFF800000);
      wr(`PWT_A_T_DWELL, 32'h0000C351);
      rd(`PWT_A_T_DWELL, 32'h00000003);
      wr(`PWT_A_T_MISC, 32'h00001F5B);
      rd(`PWT_A_T_MISC, 32'h0000003B);
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      wait_ready;
      mv(6'h03);
      chk(op_pos[23:0], 32'h00FFFFE3);
      $display("TB: test commit and power cycle done");
      steps(1'b1, 1000);
      chk(multi_rot, 32'h1);
      wr(`PWT_A_WRAP, 32'h00000014);
      wr(`PWT_A_CTRL, 32'h00000003);
      steps(1'b1, 1);
      chk(cmd_pos[23:0], 32'h0);
      chk(multi_rot, 32'h0);
      steps(1'b1, 19);
      chk(cmd_pos[23:0], 32'h13);
      steps(1'b1, 1);
      steps(1'b0, 1);
      chk(cmd_pos[23:0], 32'h13);
      wr(`PWT_A_LIM_P, 32'h00000005);
      wr(`PWT_A_PRESET, 32'h00000010);
      wr(`PWT_A_CTRL, 32'h00000017);
      preset_in <= 1'b1;
      @(posedge clk);
      preset_in <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk(cmd_pos[23:0], 32'h10);
      chk(ot_stop, 32'h0);
      wr(`PWT_A_WRAP, 32'h00000014);
      apb(`PWT_A_STATUS, 1'b0, 32'h0);
      chk(rd_v & 32'h40, 32'h40);
      wr(`PWT_A_CMD, 32'h00000010);
      rd(`PWT_A_STATUS, 32'h00000014);
      wr(`PWT_A_CTRL, 32'h00000026);
      @(posedge clk);
      chk(ot_stop, 32'h1);
      chk(ot_stop_mode, 32'h1);
      $display("TB: test wrap done");
      wr(`PWT_A_GEAR_A, 32'h00000003);
      wr(`PWT_A_CTRL, 32'h00000003);
      @(posedge clk);
      chk(wrap_warn, 32'h1);
      wr(`PWT_A_GEAR_A, 32'h00000001);
      wr(`PWT_A_WRAP, 32'h00000005);
      @(posedge clk);
      chk(wrap_warn, 32'h1);
      wr(`PWT_A_CMD, 32'h00000004);
      chk(wrap_alarm, 32'h1);
      wr(`PWT_A_CMD, 32'h00000008);
      chk(wrap_alarm, 32'h0);
      wr(`PWT_A_CTRL, 32'h00000002);
      @(posedge clk);
      chk(wrap_warn, 32'h0);
      apb(8'h80, 1'b0, 32'h0);
      chk(perr, 32'h1);
      chk(rd_v, 32'h0);
      $display("TB: test warning and refusal done");
      end_of_test;
   end
endmodule // pwt_core_test

// Checker attached to the core, watching its ports only
bind pwt_core pwt_props #(.MROT_W(MROT_W)) i_pwt_props (.clk, .nrst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nv_req, .nv_addr, .nv_ack,
   .step_en, .step_dir, .home_done, .preset_in, .op_func, .op_dwell, .cmd_pos,
   .multi_rot, .ot_stop, .wrap_warn, .wrap_alarm, .table_ready);
